// [smm_window_pkg.sv]
// constants and types shared by the system-management window decode
package smm_window_pkg;
   localparam logic [7:0] ctrl_offset = 8'h72;
   localparam logic [7:0] ctrl_reset = 8'h02;
   localparam int open_bit = 6;
   localparam int closed_bit = 5;
   localparam int lock_bit = 4;
   localparam int enable_bit = 3;
   localparam int seg_lsb = 0;
   localparam logic [2:0] seg_a0000 = 3'h2;
   localparam logic [2:0] seg_c0000 = 3'h4;
   localparam logic [3:0] a_window_top = 4'h5;
   localparam logic [4:0] a_window_hi = 5'h0a;
   localparam logic [4:0] a_window_hi2 = 5'h0b;
   localparam logic [3:0] c_window_top = 4'h6;
   localparam logic [3:0] c_window_hi = 4'h0c;
   localparam int request_phase_clock = 2;
   typedef enum logic [1:0] {
      route_pci = 2'h0,
      route_dram = 2'h1,
      route_undefined = 2'h2
   } route_e;
endpackage

// [smm_ctrl_if.sv]
// carrier of the window control fields between decode and register
`timescale 1ns/1ps
`default_nettype none
interface smm_ctrl_if;
   logic window_open;
   logic window_closed;
   logic window_lock;
   logic window_enable;
   logic [2:0] window_base_segment;
   modport reg_side (output window_open, window_closed, window_lock, window_enable,
      window_base_segment);
   modport use_side (input window_open, window_closed, window_lock, window_enable,
      window_base_segment);
endinterface
`default_nettype wire

// [smm_ctrl_reg.sv]
// window control register with lock protection
`timescale 1ns/1ps
`default_nettype none
module smm_ctrl_reg (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic cfg_write_i,
   input wire logic [7:0] cfg_wdata_i,
   output logic [7:0] cfg_value_o,
   smm_ctrl_if.reg_side ctrl
);
   logic [6:0] value;
   logic [6:0] next_value;

   always_comb begin
      next_value = value;
      if (cfg_write_i) begin
         if (value[smm_window_pkg::lock_bit]) begin
            // locked: only closed, enable and segment remain writable
            next_value[smm_window_pkg::closed_bit] = cfg_wdata_i[smm_window_pkg::closed_bit];
            next_value[smm_window_pkg::enable_bit] = cfg_wdata_i[smm_window_pkg::enable_bit];
            next_value[2:0] = cfg_wdata_i[2:0]; // R3
         end else begin
            next_value = cfg_wdata_i[6:0]; // R16
            if (cfg_wdata_i[smm_window_pkg::lock_bit]) begin
               next_value[smm_window_pkg::open_bit] = 1'b0; // R3
            end
         end
      end
   end

   // only reset clears lock: software has no path to write it to 0
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         value <= smm_window_pkg::ctrl_reset[6:0]; // R4
      end else begin
         value <= next_value;
      end
   end

   assign cfg_value_o = {1'b0, value}; // R16
   assign ctrl.window_open = value[smm_window_pkg::open_bit];
   assign ctrl.window_closed = value[smm_window_pkg::closed_bit];
   assign ctrl.window_lock = value[smm_window_pkg::lock_bit];
   assign ctrl.window_enable = value[smm_window_pkg::enable_bit];
   assign ctrl.window_base_segment = value[2:0];
endmodule
`default_nettype wire

// [smm_ram_window_decode.sv]
// system-management RAM window control and host cycle decode
// Function
// R1: open and unlocked makes window DRAM visible without sysmgmt indication.
// R2: software never sets open and closed together.
// R3: setting lock forces open to zero; lock and open become read-only.
// R4: lock set by write, cleared only by power-on reset.
// R5: closed blocks data references; sysmgmt code fetches still go to DRAM.
// R6: enabled gives 128 KB at A0000h or 64 KB at C0000h; disabled forwards to PCI.
// R7: sysmgmt indication sampled in second clock of request phase.
// R8: base segment 010 selects A0000h, 100 selects C0000h, others reserved.
// R9: addresses are never remapped; only DRAM or PCI chosen.
// R10: PCI initiators never reach the window.
// R11: memory attribute bits ignored for C0000h segment while window there.
// R12: enabled, closed open, no sysmgmt request goes to PCI.
// R13: open and closed both set unlocked gives undefined routing.
// R14: open, closed, lock matter only while enable is set.
// R15: software clears open before setting lock.
// R16: reserved top bit reads zero and ignores writes.
`timescale 1ns/1ps
`default_nettype none
module smm_ram_window_decode (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic cfg_write_i,
   input wire logic cfg_read_i,
   input wire logic [7:0] cfg_offset_i,
   input wire logic [7:0] cfg_wdata_i,
   output logic [7:0] cfg_rdata_o,
   input wire logic request_start_i,
   input wire logic [31:0] request_addr_i,
   input wire logic request_code_fetch_i,
   input wire logic sysmgmt_request_indication_n_i,
   input wire logic from_pci_initiator_i,
   input wire logic attribute_dram_i,
   output logic decode_valid_o,
   output logic claim_dram_o,
   output logic forward_pci_o,
   output logic decode_undefined_o,
   output logic in_window_o
);
   smm_ctrl_if ctrl ();
   logic [7:0] cfg_value;
   logic reg_hit;

   assign reg_hit = cfg_offset_i == smm_window_pkg::ctrl_offset;

   smm_ctrl_reg u_reg (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .cfg_write_i(cfg_write_i && reg_hit),
      .cfg_wdata_i(cfg_wdata_i),
      .cfg_value_o(cfg_value),
      .ctrl(ctrl)
   );

   function automatic logic in_window(input logic [31:0] addr, input logic [2:0] seg);
      logic hit;
      hit = 1'b0;
      if (addr[31:20] == 12'h000) begin
         case (seg) // R8
            smm_window_pkg::seg_a0000: hit = addr[19:17] == smm_window_pkg::a_window_top[2:0]; // R6
            smm_window_pkg::seg_c0000: hit = addr[19:16] == smm_window_pkg::c_window_hi; // R6
            default: hit = 1'b0;
         endcase
      end
      return hit;
   endfunction

   // request phase tracking: indication is taken on the phase's second clock
   logic phase_second;
   logic next_phase_second;
   logic [31:0] held_addr;
   logic [31:0] next_held_addr;
   logic held_code;
   logic next_held_code;
   logic held_pci;
   logic next_held_pci;

   always_comb begin
      next_phase_second = request_start_i;
      next_held_addr = request_start_i ? request_addr_i : held_addr;
      next_held_code = request_start_i ? request_code_fetch_i : held_code;
      next_held_pci = request_start_i ? from_pci_initiator_i : held_pci;
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         phase_second <= 1'b0;
         held_addr <= 32'h0000_0000;
         held_code <= 1'b0;
         held_pci <= 1'b0;
      end else begin
         phase_second <= next_phase_second;
         held_addr <= next_held_addr;
         held_code <= next_held_code;
         held_pci <= next_held_pci;
      end
   end

   // routing decision for the held host cycle
   smm_window_pkg::route_e route;
   logic hit;
   logic smm_active;

   always_comb begin
      smm_active = !sysmgmt_request_indication_n_i; // R7
      hit = in_window(held_addr, ctrl.window_base_segment);
      route = smm_window_pkg::route_pci;
      if (!hit) begin
         // outside the window, attribute bits decide normally
         route = attribute_dram_i ? smm_window_pkg::route_dram : smm_window_pkg::route_pci;
      end else if (held_pci) begin
         route = smm_window_pkg::route_pci; // R10
      end else if (!ctrl.window_enable) begin
         route = smm_window_pkg::route_pci; // R6 R14
      end else if (!ctrl.window_lock && ctrl.window_open && ctrl.window_closed) begin
         route = smm_window_pkg::route_undefined; // R13
      end else if (!ctrl.window_lock && ctrl.window_open) begin
         route = smm_window_pkg::route_dram; // R1
      end else if (!smm_active) begin
         route = smm_window_pkg::route_pci; // R12
      end else if (ctrl.window_closed && !held_code) begin
         route = smm_window_pkg::route_pci; // R5
      end else begin
         // memory attribute bits are not consulted inside the window
         route = smm_window_pkg::route_dram; // R5 R11 R9
      end
   end

   logic next_valid;
   logic next_dram;
   logic next_pci;
   logic next_undef;
   logic next_in_window;
   logic [7:0] next_rdata;

   always_comb begin
      next_valid = phase_second;
      next_dram = phase_second && route == smm_window_pkg::route_dram;
      // undefined combination is sent to PCI so the cycle still completes
      next_pci = phase_second && route != smm_window_pkg::route_dram;
      next_undef = phase_second && route == smm_window_pkg::route_undefined;
      next_in_window = phase_second && hit;
      next_rdata = (cfg_read_i && reg_hit) ? cfg_value : 8'h00;
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         decode_valid_o <= 1'b0;
         claim_dram_o <= 1'b0;
         forward_pci_o <= 1'b0;
         decode_undefined_o <= 1'b0;
         in_window_o <= 1'b0;
         cfg_rdata_o <= 8'h00;
      end else begin
         decode_valid_o <= next_valid;
         claim_dram_o <= next_dram;
         forward_pci_o <= next_pci;
         decode_undefined_o <= next_undef;
         in_window_o <= next_in_window;
         cfg_rdata_o <= next_rdata;
      end
   end
endmodule
`default_nettype wire

// [smm_window_asserts.sv]
// concurrent checks on the window decode ports
`timescale 1ns/1ps
`default_nettype none
module smm_window_asserts (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic cfg_read_i,
   input wire logic [7:0] cfg_offset_i,
   input wire logic [7:0] cfg_rdata_o,
   input wire logic request_start_i,
   input wire logic from_pci_initiator_i,
   input wire logic decode_valid_o,
   input wire logic claim_dram_o,
   input wire logic forward_pci_o,
   input wire logic decode_undefined_o,
   input wire logic in_window_o
);
   default clocking @(posedge clk_i); endclocking
   default disable iff (reset_i);
   a_valid_two_late: assert property (
      request_start_i |-> ##1 !decode_valid_o ##1 decode_valid_o) else $error("late decode");
   a_valid_has_cause: assert property (
      decode_valid_o |-> $past(request_start_i, 2)) else $error("decode without request");
   a_route_exclusive: assert property (
      decode_valid_o |-> claim_dram_o ^ forward_pci_o) else $error("route not one-hot");
   a_quiet_between: assert property (
      !decode_valid_o |-> !(claim_dram_o | forward_pci_o)) else $error("route without valid");
   a_pci_stays_out: assert property (
      request_start_i && from_pci_initiator_i |-> ##2 forward_pci_o) else $error("pci in window");
   a_undef_in_window: assert property (
      decode_undefined_o |-> in_window_o && decode_valid_o) else $error("stray undefined");
   a_read_top_zero: assert property (
      cfg_read_i |=> !cfg_rdata_o[7]) else $error("reserved bit set");
   a_lock_closes_open: assert property (
      $past(cfg_read_i) && $past(cfg_offset_i) == 8'h72 && cfg_rdata_o[4] |-> !cfg_rdata_o[6])
      else $error("open while locked");
endmodule
bind smm_ram_window_decode smm_window_asserts i_chk (.clk_i, .reset_i, .cfg_read_i,
   .cfg_offset_i, .cfg_rdata_o, .request_start_i, .from_pci_initiator_i, .decode_valid_o,
   .claim_dram_o, .forward_pci_o, .decode_undefined_o, .in_window_o);
`default_nettype wire

// [host_cycle_model.sv]
// host bus model: one memory cycle per go pulse
`timescale 1ns/1ps
`default_nettype none
module host_cycle_model (
   input wire logic clk_i,
   input wire logic go_i,
   input wire logic [31:0] addr_i,
   input wire logic code_i,
   input wire logic smm_n_i,
   output logic start_o = 1'b0,
   output logic [31:0] addr_o = 32'h0,
   output logic code_o = 1'b0,
   output logic ind_n_o = 1'b1
);
   logic g;
   logic s;
   always @(posedge clk_i) begin
      g = go_i;
      s = start_o;
      #1;
      start_o = g;
      // outside its clock the address bus is driven inverted on each clock, so it does not hold the old value
      addr_o = g ? addr_i : ~addr_o;
      code_o = g ? code_i : ~code_o;
      ind_n_o = s ? smm_n_i : 1'b1;
   end
endmodule
`default_nettype wire

// [test_smm_ram_window_decode.sv]
// self-checking bench for the system-management window decode
`timescale 1ns/1ps
`default_nettype none
module test_smm_ram_window_decode;
   logic clk_i = 0, reset_i = 1, wr = 0, rd = 0, go = 0, code = 0, smm_n = 1, pci = 0, attr = 0;
   logic [7:0] off = 8'h0, wd = 8'h0, rdata;
   logic [31:0] addr = 32'h0, addr_b;
   logic start, code_b, ind_n, valid, dram, fwd, undef, inwin;
   int n_mismatch = 0, n_compared = 0;
   always #5 clk_i = ~clk_i;
   smm_ram_window_decode i_dut (.clk_i, .reset_i, .cfg_write_i(wr), .cfg_read_i(rd),
      .cfg_offset_i(off), .cfg_wdata_i(wd), .cfg_rdata_o(rdata), .request_start_i(start),
      .request_addr_i(addr_b), .request_code_fetch_i(code_b),
      .sysmgmt_request_indication_n_i(ind_n), .from_pci_initiator_i(pci),
      .attribute_dram_i(attr), .decode_valid_o(valid), .claim_dram_o(dram),
      .forward_pci_o(fwd), .decode_undefined_o(undef), .in_window_o(inwin));
   host_cycle_model i_host (.clk_i, .go_i(go), .addr_i(addr), .code_i(code), .smm_n_i(smm_n),
      .start_o(start), .addr_o(addr_b), .code_o(code_b), .ind_n_o(ind_n));
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic finish_test;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic tick;
      @(posedge clk_i);
      #1;
   endtask
   task automatic wr_reg(input logic [7:0] d);
      wr = 1;
      off = 8'h72;
      wd = d;
      tick;
      wr = 0;
      tick;
   endtask
   task automatic rd_chk(input logic [7:0] o, input logic [7:0] exp);
      rd = 1;
      off = o;
      tick;
      rd = 0;
      chk("cfg_rdata", rdata, exp);
      tick;
   endtask
   // exp is {in_window, claim_dram, undefined}; forward_pci expected whenever dram is not
   task automatic cyc(input logic [31:0] a, input logic c, input logic s, input logic [2:0] exp);
      int i;
      addr = a;
      code = c;
      smm_n = s;
      go = 1;
      tick;
      go = 0;
      for (i = 0; i < 8 && valid !== 1'b1; i++) tick;
      if (valid !== 1'b1) begin
         n_mismatch++;
         finish_test;
      end
      chk("route", {4'h0, inwin, dram, fwd, undef}, {4'h0, exp[2:1], ~exp[1], exp[0]});
      tick;
   endtask
   initial begin
      repeat (10) @(posedge clk_i);
      #1 reset_i = 0;
      rd_chk(8'h72, 8'h02);
      rd_chk(8'h70, 8'h00);
      wr_reg(8'hca);
      rd_chk(8'h72, 8'h4a);
      cyc(32'ha0000, 0, 1, 3'b110);
      cyc(32'hbffff, 1, 1, 3'b110);
      cyc(32'hc0000, 0, 0, 3'b000);
      wr_reg(8'h2a);
      cyc(32'ha0000, 0, 0, 3'b100);
      cyc(32'ha0000, 1, 0, 3'b110);
      cyc(32'ha0000, 1, 1, 3'b100);
      pci = 1;
      cyc(32'ha0000, 1, 0, 3'b100);
      pci = 0;
      wr_reg(8'h0c);
      cyc(32'hcffff, 0, 0, 3'b110);
      attr = 1;
      cyc(32'hc0000, 0, 1, 3'b100);
      cyc(32'hd0000, 0, 1, 3'b010);
      attr = 0;
      wr_reg(8'h0b);
      cyc(32'ha0000, 0, 0, 3'b000);
      wr_reg(8'h62);
      cyc(32'ha0000, 0, 0, 3'b100);
      wr_reg(8'h6a);
      cyc(32'ha0000, 0, 1, 3'b101);
      wr_reg(8'h5a);
      rd_chk(8'h72, 8'h1a);
      wr_reg(8'h42);
      rd_chk(8'h72, 8'h12);
      wr_reg(8'h0a);
      cyc(32'ha0000, 0, 0, 3'b110);
      cyc(32'ha0000, 1, 1, 3'b100);
      reset_i = 1;
      tick;
      reset_i = 0;
      rd_chk(8'h72, 8'h02);
      wr_reg(8'h4a);
      wr_reg(8'h0a);
      wr_reg(8'h1a);
      rd_chk(8'h72, 8'h1a);
      wr_reg(8'h6a);
      rd_chk(8'h72, 8'h3a);
      cyc(32'ha0000, 0, 1, 3'b100);
      finish_test;
   end
endmodule
`default_nettype wire
